// file: hw/ahs_home_seq.v
// Automatic home search sequencer for one axis, APB register access
// What this block does
// - Runs near-home, home, index, offset steps in order without host help
// - Step one drives ramped at drive speed, decelerates on near-home
// - Near-home already active at step one start skips straight to step two
// - Search limit at start or during step one moves on to step two
// - Step two drives constant home speed, stops at once on home
// - Home active at step two start: reverse till inactive, then restart
// - Search limit in step two: reverse past home, then restart step two
// - Step three drives home speed till index, optionally index and home
// - Index active at step three start sets bit 7 error, ends search
// - Search limit in step three sets limit error bit, ends search
// - Step four outputs exactly the pulse count at drive speed
// - Optionally clears logical and real counters after offset move
// - Drive limit before or during step four stops with limit error
// - Step one can be disabled so the search begins at step two
`timescale 1ns/10ps
`default_nettype none
`include "ahs_regs.vh"
module ahs_home_seq #(
  parameter SW = 16,
  parameter PW = 32
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire nearHome,
  input wire homeIn,
  input wire encIndex,
  input wire limitPlus,
  input wire limitMinus,
  input wire encStep,
  input wire encDir,
  output reg pulseOut,
  output reg dirOut,
  output reg busy
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_NEAR = 4'h1;
  localparam [3:0] ST_NDEC = 4'h2;
  localparam [3:0] ST_HOME = 4'h3;
  localparam [3:0] ST_LREV = 4'h4;
  localparam [3:0] ST_HREV = 4'h5;
  localparam [3:0] ST_INDEX = 4'h6;
  localparam [3:0] ST_OFFS = 4'h7;

  reg [`AHS_CFG_W-1:0] cfg_q;
  reg [SW-1:0] drvSpd_q;
  reg [SW-1:0] homeSpd_q;
  reg [SW-1:0] initSpd_q;
  reg [SW-1:0] accel_q;
  reg [PW-1:0] pcount_q;
  reg [PW-1:0] remain_q;
  reg [PW-1:0] lpos_q;
  reg [PW-1:0] rpos_q;
  reg [7:0] err_q;
  reg [3:0] state_q;
  reg [3:0] prev_q;
  reg [3:0] state_d;
  reg encStepOld_q;
  reg errP;
  reg errN;
  reg errI;
  reg clrCnt;
  reg [31:0] rdMux;
  reg hit;
  wire [6:0] syncOut;
  wire sNear = syncOut[0];
  wire sHome = syncOut[1];
  wire sIdx = syncOut[2];
  wire sLimP = syncOut[3];
  wire sLimN = syncOut[4];
  wire sEncStep = syncOut[5];
  wire sEncDir = syncOut[6];

  ahs_sync #(.W(7)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({encDir, encStep, limitMinus, limitPlus, encIndex, homeIn,
          nearHome}),
    .dout(syncOut)
  );

  // APB access decode
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire [3:0] en = cfg_q[`AHS_C_EN_HI:`AHS_C_EN_LO];
  wire startReq = wr & (paddr == `AHS_OFF_CTRL) & pwdata[`AHS_C_START];
  wire errClr = wr & (paddr == `AHS_OFF_ERRSTAT);

  // Motion context
  wire moving = (state_q != ST_IDLE);
  wire entry = (state_q != prev_q) & (state_q != ST_NDEC);
  wire revDir = (state_q == ST_LREV) | (state_q == ST_HREV);
  wire dirNow = revDir ? ~cfg_q[`AHS_C_SDIR] :
                (state_q == ST_OFFS) ? cfg_q[`AHS_C_ODIR] :
                cfg_q[`AHS_C_SDIR];
  wire limAct = dirNow ? sLimN : sLimP;
  wire rampOn = (state_q == ST_NEAR) | (state_q == ST_NDEC) |
                (state_q == ST_OFFS);
  wire stopNow = (state_d != state_q) & (state_d != ST_NDEC);
  wire genRun = moving & ~entry & ~stopNow;
  wire genPulse;
  wire genStopped;
  wire idxHit = cfg_q[`AHS_C_ANDHOME] ? (sIdx & sHome) : sIdx;

  // Next enabled step after each point of the sequence
  // Start uses the enables of the very write that starts the search
  wire [3:0] enNew = pwdata[`AHS_C_EN_HI:`AHS_C_EN_LO];
  wire [3:0] fromStart = enNew[0] ? ST_NEAR : enNew[1] ? ST_HOME :
                         enNew[2] ? ST_INDEX : enNew[3] ? ST_OFFS : ST_IDLE;
  wire [3:0] fromNear = en[1] ? ST_HOME : en[2] ? ST_INDEX :
                        en[3] ? ST_OFFS : ST_IDLE;
  wire [3:0] fromHome = en[2] ? ST_INDEX : en[3] ? ST_OFFS : ST_IDLE;
  wire [3:0] fromIndex = en[3] ? ST_OFFS : ST_IDLE;

  ahs_pulse_gen #(.SW(SW)) u_gen (
    .clk(clk),
    .rst_n(rst_n),
    .run(genRun),
    .accelOn(rampOn),
    .stopDecel(state_q == ST_NDEC),
    .target(rampOn ? drvSpd_q : homeSpd_q),
    .initSpd(initSpd_q),
    .accel(accel_q),
    .pulse(genPulse),
    .stopped(genStopped)
  );

  // Sequencer next state
  always @* begin
    state_d = state_q;
    errP = 1'b0;
    errN = 1'b0;
    errI = 1'b0;
    clrCnt = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (startReq)
          state_d = fromStart;
      end
      ST_NEAR: begin
        if (entry && (sNear || limAct))
          state_d = fromNear;
        else if (limAct)
          state_d = fromNear;
        else if (sNear)
          state_d = ST_NDEC;
      end
      ST_NDEC: begin
        if (limAct || genStopped)
          state_d = fromNear;
      end
      ST_HOME: begin
        if (entry && sHome)
          state_d = ST_HREV;
        else if (sHome)
          state_d = fromHome;
        else if (limAct)
          state_d = ST_LREV;
      end
      ST_LREV: begin
        if (sHome)
          state_d = ST_HREV;
      end
      ST_HREV: begin
        if (!sHome)
          state_d = ST_HOME;
      end
      ST_INDEX: begin
        if (entry && sIdx) begin
          errI = 1'b1;
          state_d = ST_IDLE;
        end else if (limAct) begin
          errP = ~dirNow;
          errN = dirNow;
          state_d = ST_IDLE;
        end else if (idxHit && !entry) begin
          state_d = fromIndex;
        end
      end
      ST_OFFS: begin
        if (limAct) begin
          errP = ~dirNow;
          errN = dirNow;
          state_d = ST_IDLE;
        end else if (!entry && remain_q == {PW{1'b0}}) begin
          clrCnt = cfg_q[`AHS_C_CLRPOS];
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Register read mux
  always @* begin
    rdMux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `AHS_OFF_CTRL: rdMux[`AHS_CFG_W-1:0] = cfg_q &
                     ~(`AHS_CFG_W'h001 << `AHS_C_START);
      `AHS_OFF_DRVSPD: rdMux[SW-1:0] = drvSpd_q;
      `AHS_OFF_HOMESPD: rdMux[SW-1:0] = homeSpd_q;
      `AHS_OFF_INITSPD: rdMux[SW-1:0] = initSpd_q;
      `AHS_OFF_ACCEL: rdMux[SW-1:0] = accel_q;
      `AHS_OFF_PCOUNT: rdMux[PW-1:0] = pcount_q;
      `AHS_OFF_STATUS: begin
        rdMux[`AHS_S_BUSY] = busy;
        rdMux[`AHS_S_ST_HI:`AHS_S_ST_LO] = state_q;
      end
      `AHS_OFF_ERRSTAT: rdMux[7:0] = err_q;
      `AHS_OFF_LPOS: rdMux[PW-1:0] = lpos_q;
      `AHS_OFF_RPOS: rdMux[PW-1:0] = rpos_q;
      default: hit = 1'b0;
    endcase
  end

  // APB slave: one wait state, read data captured on the same edge that raises pready
  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= ~hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Software registers; config frozen while a search runs
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= `AHS_CTRL_RST;
      drvSpd_q <= `AHS_SPD_RST;
      homeSpd_q <= `AHS_SPD_RST;
      initSpd_q <= `AHS_SPD_RST;
      accel_q <= `AHS_SPD_RST;
      pcount_q <= {PW{1'b0}};
    end else if (wr && !busy) begin
      case (paddr)
        `AHS_OFF_CTRL: cfg_q <= pwdata[`AHS_CFG_W-1:0];
        `AHS_OFF_DRVSPD: drvSpd_q <= pwdata[SW-1:0];
        `AHS_OFF_HOMESPD: homeSpd_q <= pwdata[SW-1:0];
        `AHS_OFF_INITSPD: initSpd_q <= pwdata[SW-1:0];
        `AHS_OFF_ACCEL: accel_q <= pwdata[SW-1:0];
        `AHS_OFF_PCOUNT: pcount_q <= pwdata[PW-1:0];
        default: ;
      endcase
    end
  end

  // Axis error status: write one to clear, hardware set wins
  always @(posedge clk) begin
    if (!rst_n) begin
      err_q <= 8'h00;
    end else begin
      err_q <= (err_q & ~(errClr ? pwdata[7:0] : 8'h00)) |
               ({7'h00, errI} << `AHS_E_IDX) |
               ({7'h00, errP} << `AHS_E_LIMP) |
               ({7'h00, errN} << `AHS_E_LIMN);
    end
  end

  // Sequencer state, offset counter, outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      prev_q <= ST_IDLE;
      remain_q <= {PW{1'b0}};
      busy <= 1'b0;
      pulseOut <= 1'b0;
      dirOut <= 1'b0;
    end else begin
      state_q <= state_d;
      prev_q <= state_q;
      busy <= (state_d != ST_IDLE);
      pulseOut <= genPulse;
      dirOut <= dirNow;
      if (state_q != ST_OFFS)
        remain_q <= pcount_q;
      else if (genPulse)
        remain_q <= remain_q - 1'b1;
    end
  end

  // Logical and real position counters
  always @(posedge clk) begin
    if (!rst_n) begin
      lpos_q <= {PW{1'b0}};
      rpos_q <= {PW{1'b0}};
      encStepOld_q <= 1'b0;
    end else begin
      encStepOld_q <= sEncStep;
      if (clrCnt) begin
        lpos_q <= {PW{1'b0}};
        rpos_q <= {PW{1'b0}};
      end else begin
        if (genPulse)
          lpos_q <= dirNow ? lpos_q - 1'b1 : lpos_q + 1'b1;
        if (sEncStep && !encStepOld_q)
          rpos_q <= sEncDir ? rpos_q - 1'b1 : rpos_q + 1'b1;
      end
    end
  end
endmodule // ahs_home_seq
`default_nettype wire

// file: inc/ahs_regs.vh
// Register map, field positions and reset values of the home sequencer
`ifndef AHS_REGS_VH
`define AHS_REGS_VH
`define AHS_OFF_CTRL 8'h00
`define AHS_OFF_DRVSPD 8'h04
`define AHS_OFF_HOMESPD 8'h08
`define AHS_OFF_INITSPD 8'h0c
`define AHS_OFF_ACCEL 8'h10
`define AHS_OFF_PCOUNT 8'h14
`define AHS_OFF_STATUS 8'h18
`define AHS_OFF_ERRSTAT 8'h1c
`define AHS_OFF_LPOS 8'h20
`define AHS_OFF_RPOS 8'h24
`define AHS_C_START 0
`define AHS_C_SDIR 1
`define AHS_C_ODIR 2
`define AHS_C_EN_LO 3
`define AHS_C_EN_HI 6
`define AHS_C_ANDHOME 7
`define AHS_C_CLRPOS 8
`define AHS_CFG_W 9
`define AHS_CTRL_RST 9'h078
`define AHS_E_LIMP 2
`define AHS_E_LIMN 3
`define AHS_E_IDX 7
`define AHS_S_BUSY 0
`define AHS_S_ST_LO 4
`define AHS_S_ST_HI 7
`define AHS_ACC_DIV 16'h0009
`define AHS_SPD_RST 16'h0000
`endif

// file: hw/ahs_sync.v
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/10ps
`default_nettype none
module ahs_sync #(
  parameter W = 7
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (s2_q & s3_q) | (dout & (s2_q | s3_q));
    end
  end
endmodule // ahs_sync
`default_nettype wire

// file: hw/ahs_pulse_gen.v
// Rate generator with linear ramp and decelerating stop
`timescale 1ns/10ps
`default_nettype none
`include "ahs_regs.vh"
module ahs_pulse_gen #(
  parameter SW = 16,
  parameter DIVW = 16,
  parameter [DIVW-1:0] DIV = `AHS_ACC_DIV
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire accelOn,
  input wire stopDecel,
  input wire [SW-1:0] target,
  input wire [SW-1:0] initSpd,
  input wire [SW-1:0] accel,
  output wire pulse,
  output wire stopped
);
  reg [SW-1:0] rate_q;
  reg [SW-1:0] acc_q;
  reg [DIVW-1:0] div_q;
  wire tick = (div_q == {DIVW{1'b0}});
  wire [SW:0] accSum = {1'b0, acc_q} + {1'b0, rate_q};
  wire [SW:0] decLim = {1'b0, initSpd} + {1'b0, accel};
  wire [SW:0] upSum = {1'b0, rate_q} + {1'b0, accel};
  wire useRamp = accelOn & (initSpd < target);
  assign pulse = run & accSum[SW];
  assign stopped = stopDecel & (rate_q == {SW{1'b0}});
  always @(posedge clk) begin
    if (!rst_n || !run) begin
      rate_q <= {SW{1'b0}};
      acc_q <= {SW{1'b0}};
      div_q <= DIV;
    end else begin
      div_q <= tick ? DIV : div_q - 1'b1;
      acc_q <= accSum[SW-1:0];
      if (rate_q == {SW{1'b0}}) begin
        if (!stopDecel)
          rate_q <= useRamp ? initSpd : target;
      end else if (stopDecel) begin
        if (!accelOn)
          rate_q <= {SW{1'b0}};
        else if (tick)
          rate_q <= ({1'b0, rate_q} > decLim) ? rate_q - accel : {SW{1'b0}};
      end else if (tick && accelOn && rate_q < target) begin
        rate_q <= (upSum > {1'b0, target}) ? target : upSum[SW-1:0];
      end
    end
  end
endmodule // ahs_pulse_gen
`default_nettype wire

// file: verif/ahs_props.sv
// Concurrent checks on the home sequencer ports
`timescale 1ns/10ps
`default_nettype none
`include "ahs_regs.vh"
module ahs_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pulseOut,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire wrDone = psel && penable && pready && pwrite;
  property p_rdy_lat;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat)
    else $error("pready not in second cycle after setup");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one)
    else $error("pready longer than one cycle");
  property p_err_rdy;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("pslverr without pready or with data");
  property p_prd_hold;
    !pready |-> $stable(prdata);
  endproperty
  a_prd_hold: assert property (p_prd_hold)
    else $error("prdata moved outside an answer");
  property p_pulse_busy;
    pulseOut |-> busy;
  endproperty
  a_pulse_busy: assert property (p_pulse_busy)
    else $error("pulse while idle");
  property p_pulse_gap;
    pulseOut |=> !pulseOut;
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("pulse wider than one cycle");
  property p_busy_start;
    wrDone && paddr == `AHS_OFF_CTRL && pwdata[0] && !busy |=> busy;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("start write did not raise busy");
  property p_start_quiet;
    $rose(busy) |-> !pulseOut;
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("pulse in search entry cycle");
  property p_idle_stays;
    !busy && !wrDone |=> !busy;
  endproperty
  a_idle_stays: assert property (p_idle_stays)
    else $error("busy rose without a start write");
  c_err: cover property (pslverr);
  c_end: cover property ($fell(busy));
  c_pulse: cover property (pulseOut ##1 busy);
endmodule // ahs_props
bind ahs_home_seq ahs_props u_props (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pulseOut(pulseOut), .busy(busy));
`default_nettype wire

// file: verif/ahs_axis_model.sv
// Axis model: motor position, home sensors, limits, encoder
`timescale 1ns/10ps
`default_nettype none
module ahs_axis_model (
  input wire logic clk,
  input wire logic pulseOut,
  input wire logic dirOut,
  input wire logic load,
  input wire logic merged,
  input wire logic signed [31:0] loadPos,
  output logic nearHome,
  output logic homeIn,
  output logic encIndex,
  output logic limitPlus,
  output logic limitMinus,
  output logic encStep,
  output logic encDir,
  output integer pos
);
  initial pos = 0;
  initial encStep = 1'b0;
  initial encDir = 1'b0;
  logic stepDly = 1'b0;
  always @(posedge clk) begin
    if (load) pos <= loadPos;
    else if (pulseOut) pos <= dirOut ? pos - 1 : pos + 1;
    stepDly <= pulseOut;
    encStep <= pulseOut | stepDly;
    encDir <= dirOut;
  end
  // Sensors are windows on the axis position
  assign nearHome = merged ? homeIn : pos >= 100;
  assign homeIn = pos >= 140 && pos < 150;
  assign encIndex = pos > 0 && pos % 64 == 0;
  assign limitPlus = pos >= 300;
  assign limitMinus = pos <= -300;
endmodule // ahs_axis_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the home sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ahs_regs.vh"
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, load = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, rdat;
  logic signed [31:0] loadPos = 0;
  logic rerr;
  wire [31:0] prdata;
  wire pready, pslverr, nearHome, homeIn, encIndex, limitPlus, limitMinus;
  wire encStep, encDir, pulseOut, dirOut, busy;
  integer pos, p0, n_fail = 0, num_checks = 0;
  logic merged = 0, encOld = 0, busyOld = 0;
  integer encRise = 0, d1 = 0, d2 = 0, d3 = 0, d4 = 0, snap = 0, rclr = 0;
  always #50 clk = ~clk;
  // Encoder strobes still in flight when the counters clear land after it
  always @(posedge clk) begin
    encOld <= encStep;
    if (encStep && !encOld) encRise <= encRise + 1;
    d1 <= encRise;
    d2 <= d1;
    d3 <= d2;
    d4 <= d3;
    busyOld <= busy;
    if (busyOld && !busy) snap <= d4;
  end
  ahs_home_seq dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nearHome(nearHome), .homeIn(homeIn), .encIndex(encIndex),
    .limitPlus(limitPlus), .limitMinus(limitMinus), .encStep(encStep),
    .encDir(encDir), .pulseOut(pulseOut), .dirOut(dirOut), .busy(busy));
  ahs_axis_model model (.clk(clk), .pulseOut(pulseOut), .dirOut(dirOut),
    .load(load), .merged(merged), .loadPos(loadPos),
    .nearHome(nearHome), .homeIn(homeIn),
    .encIndex(encIndex), .limitPlus(limitPlus), .limitMinus(limitMinus),
    .encStep(encStep), .encDir(encDir), .pos(pos));
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    integer k;
    begin
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge clk);
        k++;
      end
      if (k == 20) n_fail++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rdat)
  endtask
  task automatic setPos(input integer p);
    load <= 1'b1;
    loadPos <= p;
    @(posedge clk);
    load <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic go(input logic [31:0] cfg);
    integer k;
    begin
      k = 0;
      apb(1'b1, `AHS_OFF_CTRL, cfg);
      `CHK("busy", 1'b1, busy)
      while (busy !== 1'b0 && k < 20000) begin
        @(posedge clk);
        k++;
      end
      `CHK("busy end", 1'b0, busy)
    end
  endtask
  task automatic t_regs;
    rdc("ctrl", `AHS_OFF_CTRL, 32'h78);
    rdc("errs", `AHS_OFF_ERRSTAT, 32'h0);
    rdc("hspd", `AHS_OFF_HOMESPD, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, rerr)
    apb(1'b1, `AHS_OFF_DRVSPD, 32'h4000);
    apb(1'b1, `AHS_OFF_HOMESPD, 32'h2000);
    apb(1'b1, `AHS_OFF_INITSPD, 32'h3000);
    apb(1'b1, `AHS_OFF_ACCEL, 32'h1000);
    rdc("hspd wr", `AHS_OFF_HOMESPD, 32'h2000);
    $display("test regs done");
  endtask
  task automatic t_full;
    setPos(0);
    apb(1'b1, `AHS_OFF_PCOUNT, 32'h5);
    go(32'h179);
    repeat (8) @(posedge clk);
    rclr = encRise - snap;
    `CHK("pos full", 1'b1, pos >= 197 && pos <= 198)
    rdc("lpos clr", `AHS_OFF_LPOS, 32'h0);
    rdc("rpos clr", `AHS_OFF_RPOS, rclr);
    p0 = pos;
    apb(1'b1, `AHS_OFF_PCOUNT, 32'h7);
    go(32'h45);
    repeat (8) @(posedge clk);
    `CHK("offs", -7, pos - p0)
    rdc("lpos", `AHS_OFF_LPOS, 32'hfffffff9);
    rdc("rpos", `AHS_OFF_RPOS, rclr - 7);
    $display("test full done");
  endtask
  task automatic t_home(input string n, input integer p,
    input logic [31:0] cfg);
    setPos(p);
    go(cfg);
    `CHK(n, 1'b1, pos >= 140 && pos <= 141)
    rdc("errs", `AHS_OFF_ERRSTAT, 32'h0);
    $display("test %s done", n);
  endtask
  task automatic t_err(input string n, input integer p,
    input logic [31:0] cfg, input logic [31:0] e);
    setPos(p);
    go(cfg);
    rdc(n, `AHS_OFF_ERRSTAT, e);
    apb(1'b1, `AHS_OFF_ERRSTAT, 32'hff);
    rdc("errs clr", `AHS_OFF_ERRSTAT, 32'h0);
    $display("test %s done", n);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_full;
    t_home("near on", 120, 32'h19);
    t_home("home on", 145, 32'h11);
    t_home("lim2", 250, 32'h11);
    merged <= 1'b1;
    t_home("merged", 0, 32'h19);
    merged <= 1'b0;
    t_err("lim3", 310, 32'h21, 32'h4);
    t_err("idx", 256, 32'h21, 32'h80);
    t_err("lim4", -310, 32'h45, 32'h8);
    end_of_test;
  end
  initial begin
    #5000000;
    n_fail++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
